// File: shared/lsbm_pkg.sv
`default_nettype none
package lsbm_pkg;
    // ****************************************************************
    // Access sizes as presented by the pipeline.
    // ****************************************************************
    localparam logic [1:0] SIZE_BYTE = 2'h0; // One byte.
    localparam logic [1:0] SIZE_HALF = 2'h1; // Two bytes.
    localparam logic [1:0] SIZE_WORD = 2'h2; // Four bytes.

    // ****************************************************************
    // Bus shape and limits.
    // ****************************************************************
    localparam int          ADDR_W       = 32;      // Address width.
    localparam int          DATA_W       = 32;      // Data width.
    localparam int          BE_W         = 4;       // Byte enable width.
    localparam logic [1:0]  MAX_OUTSTAND = 2'h2;    // Granted but unanswered limit.
    localparam logic [3:0]  BE_BYTE      = 4'h1;    // Enable mask for one byte.
    localparam logic [3:0]  BE_HALF      = 4'h3;    // Enable mask for two bytes.
    localparam logic [3:0]  BE_WORD      = 4'hf;    // Enable mask for four bytes.
    localparam logic [31:0] WORD_STEP    = 32'h4;   // Distance to next word.
    localparam logic [31:0] WORD_MASK    = 32'hfffffffc; // Clears the byte offset.
endpackage
`default_nettype wire

// File: verilog/lsbm_core.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: Request held until grant is sampled.
// RULE_02: Request parity is odd with request.
// RULE_03: Memory drives odd grant and response parity.
// RULE_04: Address phase changes only after grant.
// RULE_05: Byte enables mark accessed bytes.
// RULE_06: Write enable high for stores only.
// RULE_07: Memory pulses one response per transaction.
// RULE_08: Response data used only when valid.
// RULE_09: Early or same-cycle grant is tolerated.
// RULE_10: Response comes at least a cycle later.
// RULE_11: Responses return in request order.
// RULE_12: At most two transactions outstanding.
// RULE_13: Byte, halfword and word accesses supported.
// RULE_14: Word-crossing main accesses split in two.
// RULE_15: Lower address half issued first.
// RULE_16: Misaligned I/O access traps instead.
// RULE_17: Optional user, id and ready signals absent.
// RULE_18: Single write buffer for bufferable stores.
// RULE_19: Buffered store does not stall execution.
// RULE_20: Memory still grants and answers buffered stores.
// RULE_21: All transfers leave in program order.
// RULE_22: Buffer drained before fence or sleep.
// RULE_23: Reset leaves bus idle and counters empty.
// No address-user, write-user, id, response-ready or response-user ports exist. [RULE_17]
module lsbm_core (
    input  wire logic        sys_clk_in,            // Core clock.
    input  wire logic        reset_in,              // Synchronous reset, high.
    input  wire logic        op_valid_in,           // Pipeline offers an access.
    input  wire logic        op_write_in,           // Access is a store.
    input  wire logic [1:0]  op_size_in,            // Access size code.
    input  wire logic [31:0] op_addr_in,            // Byte address.
    input  wire logic [31:0] op_wdata_in,           // Store data, low aligned.
    input  wire logic        op_main_in,            // Address is in main memory.
    input  wire logic        op_bufferable_in,      // Address is bufferable.
    input  wire logic        drain_in,              // Fence or sleep wants drain.
    output logic             op_ready_out,          // Access accepted this cycle.
    output logic             op_trap_out,           // Misaligned I/O trap pulse.
    output logic             op_done_out,           // Load or store finished pulse.
    output logic [31:0]      op_rdata_out,          // Load data, low aligned.
    output logic             op_error_out,          // Finished access saw an error.
    output logic             drained_out,           // Buffer and bus are empty.
    output logic             lsu_req_valid_out,     // Bus request valid.
    output logic             lsu_req_parity_out,    // Odd parity of request.
    input  wire logic        lsu_grant_in,          // Bus grant.
    input  wire logic        lsu_grant_parity_in,   // Odd parity of grant.
    output logic [31:0]      lsu_addr_out,          // Word address.
    output logic             lsu_write_enable_out,  // High for writes.
    output logic [3:0]       lsu_byte_enables_out,  // Active byte lanes.
    output logic [31:0]      lsu_wdata_out,         // Lane-placed store data.
    input  wire logic        lsu_resp_valid_in,     // Response valid.
    input  wire logic        lsu_resp_valid_parity_in, // Odd parity of response.
    input  wire logic [31:0] lsu_read_word_in,      // Read data.
    input  wire logic        lsu_resp_error_in,     // Response error.
    output logic             parity_fault_out       // Grant or response parity broke.
);
    // ****************************************************************
    // State.
    // ****************************************************************
    // Issue states: idle, first half issuing, second half issuing.
    typedef enum logic [1:0] {LSBM_IDLE, LSBM_FIRST, LSBM_SECOND} lsbm_phase_e;

    typedef struct packed {
        lsbm_phase_e phase;        // Issue progress of current access.
        logic        req;          // Request line.
        logic [31:0] addr;         // Current word address.
        logic        we;           // Current write enable.
        logic [3:0]  be;           // Current byte enables.
        logic [31:0] wdata;        // Current lane data.
        logic [31:0] addr2;        // Second half word address.
        logic [3:0]  be2;          // Second half enables.
        logic [31:0] wdata2;       // Second half lane data.
        logic [1:0]  outst;        // Granted, unanswered count.
        logic        q0_last;      // Oldest outstanding ends an access.
        logic        q0_buf;       // Oldest outstanding is buffered store.
        logic        q1_last;      // Younger outstanding ends an access.
        logic        q1_buf;       // Younger outstanding is buffered store.
        logic [1:0]  shift;        // Byte offset of the waited access.
        logic        split;        // Waited access had two halves.
        logic        part;         // First half already answered.
        logic [31:0] low_word;     // First half read data.
        logic        err;          // Error gathered over halves.
        logic        cur_buf;      // Access in flight is buffered.
        logic        buf_full;     // Write buffer holds a store.
        logic        waiting;      // Pipeline waits for this access.
        logic        ready;        // Accept pulse.
        logic        trap;         // Trap pulse.
        logic        done;         // Done pulse.
        logic [31:0] rdata;        // Returned load data.
        logic        error;        // Returned error.
        logic        drained;      // Drain complete level.
        logic        pfault;       // Parity fault level.
        logic        g_s1;         // Grant parity check, stage one.
        logic        r_s1;         // Response parity check, stage one.
        logic        reqpar;       // Registered odd parity of the request line.
    } lsbm_state_s;

    lsbm_state_s st;       // Registered state.
    lsbm_state_s next_st;  // Next state.

    // Byte enable mask for a size at a byte offset, eight bits wide for spill.
    function automatic logic [7:0] lsbm_mask(input logic [1:0] size, input logic [1:0] off);
        logic [3:0] base;
        base = (size == lsbm_pkg::SIZE_WORD) ? lsbm_pkg::BE_WORD :
               (size == lsbm_pkg::SIZE_HALF) ? lsbm_pkg::BE_HALF : lsbm_pkg::BE_BYTE;
        return {4'h0, base} << off;
    endfunction

    // ****************************************************************
    // Next state.
    // ****************************************************************
    // One process covers issue, response tracking and the buffer.
    always_comb begin
        logic [7:0]  m;
        logic [63:0] wd;
        logic        mis;
        logic        grant_now;
        logic        can_issue;
        logic        resp;
        logic [31:0] merged;
        logic [63:0] both;
        m = lsbm_mask(op_size_in, op_addr_in[1:0]);
        wd = {32'h0, op_wdata_in} << {op_addr_in[1:0], 3'h0};
        mis = (m[7:4] != 4'h0) || ((op_size_in == lsbm_pkg::SIZE_WORD) && (op_addr_in[1:0] != 2'h0))
              || ((op_size_in == lsbm_pkg::SIZE_HALF) && op_addr_in[0]);
        next_st = st;
        next_st.ready = 1'b0;
        next_st.trap = 1'b0;
        next_st.done = 1'b0;
        // Grant before request is ignored; only a grant with our request counts. [RULE_09]
        grant_now = st.req && lsu_grant_in;
        resp = lsu_resp_valid_in;
        merged = 32'h0;
        both = 64'h0;
        // Responses pop the oldest entry; in-order return is relied on. [RULE_11] [RULE_20]
        if (resp) begin
            next_st.q0_last = st.q1_last;
            next_st.q0_buf = st.q1_buf;
            if (st.q0_buf) begin
                if (st.q0_last) begin
                    next_st.buf_full = 1'b0;
                end
            end else if (!st.q0_last) begin
                // Read word and error are sampled only under response valid. [RULE_08]
                next_st.part = 1'b1;
                next_st.low_word = lsu_read_word_in;
                next_st.err = lsu_resp_error_in;
            end else begin
                both = st.part ? {lsu_read_word_in, st.low_word} : {32'h0, lsu_read_word_in};
                merged = 32'(both >> {st.shift, 3'h0});
                next_st.done = 1'b1;
                next_st.waiting = 1'b0;
                next_st.rdata = merged;
                next_st.error = st.err | lsu_resp_error_in;
                next_st.part = 1'b0;
                next_st.err = 1'b0;
            end
        end
        // Grants push a new entry behind any left after the pop.
        if (grant_now) begin
            if ((resp ? st.outst - 2'h1 : st.outst) == 2'h0) begin
                next_st.q0_last = st.phase != LSBM_FIRST || !st.split;
                next_st.q0_buf = st.cur_buf;
            end else begin
                next_st.q1_last = st.phase != LSBM_FIRST || !st.split;
                next_st.q1_buf = st.cur_buf;
            end
        end
        next_st.outst = st.outst + {1'b0, grant_now} - {1'b0, resp};
        // Request stays up until a grant is seen. [RULE_01] [RULE_04]
        if (grant_now) begin
            next_st.req = 1'b0;
            if (st.phase == LSBM_FIRST && st.split) begin
                // Upper half follows the lower one. [RULE_15]
                next_st.phase = LSBM_SECOND;
                next_st.addr = st.addr2;
                next_st.be = st.be2;
                next_st.wdata = st.wdata2;
            end else begin
                next_st.phase = LSBM_IDLE;
            end
        end
        // Raise a request only while fewer than two remain after this cycle. [RULE_12]
        can_issue = next_st.outst < lsbm_pkg::MAX_OUTSTAND;
        if (st.phase == LSBM_SECOND && !st.req && can_issue) begin
            next_st.req = 1'b1;
        end
        // New access only when idle, nothing waited on, program order kept. [RULE_21]
        if (st.phase == LSBM_IDLE && !st.waiting && op_valid_in && !st.ready && !st.trap) begin
            if (mis && !op_main_in) begin
                next_st.trap = 1'b1; // [RULE_16]
                next_st.ready = 1'b1;
            end else if (!(op_write_in && op_bufferable_in && st.buf_full) && can_issue) begin
                next_st.ready = 1'b1;
                next_st.phase = LSBM_FIRST;
                next_st.req = 1'b1;
                next_st.addr = op_addr_in & lsbm_pkg::WORD_MASK;
                next_st.addr2 = (op_addr_in & lsbm_pkg::WORD_MASK) + lsbm_pkg::WORD_STEP;
                next_st.we = op_write_in; // [RULE_06]
                next_st.be = m[3:0]; // [RULE_05] [RULE_13]
                next_st.be2 = m[7:4];
                next_st.wdata = wd[31:0];
                next_st.wdata2 = wd[63:32];
                next_st.split = m[7:4] != 4'h0; // [RULE_14]
                next_st.shift = op_addr_in[1:0];
                next_st.cur_buf = op_write_in && op_bufferable_in; // [RULE_18]
                // Buffered stores release the pipeline at once. [RULE_19]
                next_st.waiting = !(op_write_in && op_bufferable_in);
                next_st.buf_full = st.buf_full | (op_write_in && op_bufferable_in);
            end
        end
        // Drain completes only with buffer empty and bus quiet. [RULE_22]
        next_st.drained = drain_in && !next_st.buf_full && next_st.outst == 2'h0
                          && next_st.phase == LSBM_IDLE;
        // Partner parity checked after two flops. [RULE_03]
        next_st.g_s1 = lsu_grant_in ^ lsu_grant_parity_in;
        next_st.r_s1 = lsu_resp_valid_in ^ lsu_resp_valid_parity_in;
        next_st.pfault = !st.g_s1 || !st.r_s1;
        next_st.rdata = next_st.done ? next_st.rdata : st.rdata;
        // Parity is computed from the next request so that it stays a flop output. [RULE_02]
        next_st.reqpar = ~next_st.req;
        if (reset_in) begin
            next_st = '0; // [RULE_23]
            next_st.g_s1 = 1'b1;
            next_st.r_s1 = 1'b1;
            next_st.reqpar = 1'b1;
        end
    end

    // Grant and response are same-domain bus signals, so parity uses them directly.
    always_ff @(posedge sys_clk_in) begin
        st <= next_st;
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // All outputs are straight flop copies.
    assign op_ready_out = st.ready;
    assign op_trap_out = st.trap;
    assign op_done_out = st.done;
    assign op_rdata_out = st.rdata;
    assign op_error_out = st.error;
    assign drained_out = st.drained;
    assign lsu_req_valid_out = st.req;
    assign lsu_req_parity_out = st.reqpar; // [RULE_02]
    assign lsu_addr_out = st.addr;
    assign lsu_write_enable_out = st.we;
    assign lsu_byte_enables_out = st.be;
    assign lsu_wdata_out = st.wdata;
    assign parity_fault_out = st.pfault;
endmodule // lsbm_core
`default_nettype wire

// File: dv/lsbm_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ************
// Bus protocol checker.
// ************
module lsbm_core_asserts (
    input wire logic        sys_clk_in,           // Clock.
    input wire logic        reset_in,             // Reset.
    input wire logic        op_valid_in,          // Offer.
    input wire logic        op_write_in,          // Store.
    input wire logic [1:0]  op_size_in,           // Size.
    input wire logic [31:0] op_addr_in,           // Address.
    input wire logic        op_main_in,           // Main region.
    input wire logic        op_ready_out,         // Taken.
    input wire logic        op_trap_out,          // Trap.
    input wire logic        lsu_req_valid_out,    // Request.
    input wire logic        lsu_req_parity_out,   // Request parity.
    input wire logic        lsu_grant_in,         // Grant.
    input wire logic [31:0] lsu_addr_out,         // Bus address.
    input wire logic        lsu_write_enable_out, // Write.
    input wire logic [3:0]  lsu_byte_enables_out, // Lanes.
    input wire logic        lsu_resp_valid_in     // Response.
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    logic [2:0] outstanding; // One bit wider than needed, so an overflow stays visible.
    // Grants in, responses out; only granted requests count.
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            outstanding <= 3'h0;
        end else begin
            outstanding <= outstanding + {2'h0, lsu_req_valid_out & lsu_grant_in} - {2'h0, lsu_resp_valid_in};
        end
    end
    // The bus must have been idle before, or an older buffered store may own the request.
    sequence s_waiting; lsu_req_valid_out && !lsu_grant_in; endsequence
    sequence s_fresh; op_ready_out && !op_trap_out && !$past(lsu_req_valid_out); endsequence
    a_req_hold: assert property (s_waiting |=> lsu_req_valid_out) else $error("request dropped early");
    a_req_parity: assert property (lsu_req_parity_out != lsu_req_valid_out) else $error("bad parity");
    a_phase_stable: assert property (s_waiting |=> $stable(lsu_addr_out) && $stable(lsu_byte_enables_out)
        && $stable(lsu_write_enable_out)) else $error("address phase moved");
    a_word_request: assert property (s_fresh ##0 (op_size_in == lsbm_pkg::SIZE_WORD && op_addr_in[1:0] == 2'h0)
        |-> lsu_req_valid_out && lsu_byte_enables_out == lsbm_pkg::BE_WORD && lsu_write_enable_out == op_write_in
        && lsu_addr_out == op_addr_in) else $error("word request wrong");
    a_split_low: assert property (s_fresh ##0 (op_main_in && op_size_in == lsbm_pkg::SIZE_WORD && op_addr_in[1:0] != 2'h0)
        |-> lsu_addr_out == (op_addr_in & lsbm_pkg::WORD_MASK) && lsu_byte_enables_out == (lsbm_pkg::BE_WORD << op_addr_in[1:0]))
        else $error("split lower half wrong");
    a_outstanding_max: assert property (outstanding <= 3'h2) else $error("too many outstanding");
    a_io_trap: assert property (op_valid_in && !op_main_in && op_size_in == lsbm_pkg::SIZE_WORD && op_addr_in[1:0] != 2'h0
        && !op_ready_out |-> ##[1:40] op_trap_out && !lsu_req_valid_out) else $error("misaligned io not trapped");
    a_reset_idle: assert property ($past(reset_in) |-> !lsu_req_valid_out && outstanding == 3'h0) else $error("busy after reset");
endmodule // lsbm_core_asserts
bind lsbm_core lsbm_core_asserts u_chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in),
    .op_write_in(op_write_in), .op_size_in(op_size_in), .op_addr_in(op_addr_in), .op_main_in(op_main_in),
    .op_ready_out(op_ready_out), .op_trap_out(op_trap_out), .lsu_req_valid_out(lsu_req_valid_out),
    .lsu_req_parity_out(lsu_req_parity_out), .lsu_grant_in(lsu_grant_in), .lsu_addr_out(lsu_addr_out),
    .lsu_write_enable_out(lsu_write_enable_out), .lsu_byte_enables_out(lsu_byte_enables_out),
    .lsu_resp_valid_in(lsu_resp_valid_in));
`default_nettype wire

// File: dv/lsbm_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ************
// Data memory model on the far side of the bus.
// ************
module lsbm_mem (
    input  wire logic        clk_in,           // Clock.
    input  wire logic        reset_in,         // Reset.
    input  wire logic        slow_in,          // Wait states on.
    input  wire logic        req_in,           // Request.
    input  wire logic [31:0] addr_in,          // Word address.
    input  wire logic        we_in,            // Write.
    input  wire logic [3:0]  be_in,            // Lanes.
    input  wire logic [31:0] wdata_in,         // Write data.
    output logic             grant_out,        // Grant.
    output logic             grant_parity_out, // Grant parity.
    output logic             resp_valid_out,   // Response.
    output logic             resp_parity_out,  // Response parity.
    output logic [31:0]      read_word_out     // Read data.
);
    logic [31:0] mem [0:15]; // Sixteen words, the address wraps above that.
    logic [31:0] pend [$];   // Answers owed, oldest first.
    int          wait_cnt;   // Cycles the request has waited.
    int          resp_dly;   // Cycles before the next answer.
    // Prompt mode grants even with no request, which the master has to tolerate.
    assign grant_out        = slow_in ? (req_in && wait_cnt == 2) : 1'b1;
    assign grant_parity_out = ~grant_out;
    assign resp_parity_out  = ~resp_valid_out;
    // Captures the address phase at the grant and answers each grant once, in order.
    always @(posedge clk_in) begin
        resp_valid_out <= 1'b0;
        read_word_out  <= ~read_word_out; // Garbage outside a response.
        if (reset_in) begin
            pend.delete();
            wait_cnt = 0;
            resp_dly = 0;
            for (int i = 0; i < 16; i++) mem[i] = 32'h0;
        end else begin
            if (req_in && grant_out) begin
                if (slow_in && pend.size() == 0) resp_dly = 2;
                wait_cnt = 0;
                for (int b = 0; b < 4; b++) if (we_in && be_in[b]) mem[addr_in[5:2]][8*b +: 8] = wdata_in[8*b +: 8];
                pend.push_back(mem[addr_in[5:2]]);
            end else if (req_in) begin
                wait_cnt = wait_cnt + 1;
            end
            if (resp_dly > 0) begin
                resp_dly = resp_dly - 1;
            end else if (pend.size() > 0) begin
                resp_valid_out <= 1'b1;
                read_word_out  <= pend.pop_front();
                resp_dly = slow_in ? 3 : 0;
            end
        end
    end
endmodule // lsbm_mem
`default_nettype wire

// File: dv/lsbm_core_test.sv
`timescale 1ns/1ps
`default_nettype none
// ************
// Load-store bus master bench.
// ************
module lsbm_core_test;
    logic        sys_clk_in = 1'b0, reset_in = 1'b1, op_valid_in = 1'b0, op_write_in = 1'b0; // Clock, reset, offer.
    logic        op_main_in = 1'b1, op_bufferable_in = 1'b0, drain_in = 1'b0, slow = 1'b0; // Attributes.
    logic [1:0]  op_size_in = 2'h0;                                    // Size code.
    logic [31:0] op_addr_in = 32'h0, op_wdata_in = 32'h0, rd, rdata, addr, wdata, rword; // Data paths.
    logic        tr, op_ready_out, op_trap_out, op_done_out, drained_out, req, par, gnt, gpar, we, rv, rvpar, fault, oerr; // Flags.
    logic [3:0]  be;                                                   // Lanes.
    int          err_count = 0, num_checks = 0;                        // Tallies.
    logic [31:0] gaddr [$];                                            // Granted addresses.
    always #5 sys_clk_in = ~sys_clk_in;
    // Logs every accepted bus request.
    always @(posedge sys_clk_in) if (req && gnt) gaddr.push_back(addr);
    lsbm_core dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in), .op_write_in(op_write_in),
        .op_size_in(op_size_in), .op_addr_in(op_addr_in), .op_wdata_in(op_wdata_in), .op_main_in(op_main_in),
        .op_bufferable_in(op_bufferable_in), .drain_in(drain_in), .op_ready_out(op_ready_out), .op_trap_out(op_trap_out),
        .op_done_out(op_done_out), .op_rdata_out(rdata), .op_error_out(oerr), .drained_out(drained_out),
        .lsu_req_valid_out(req), .lsu_req_parity_out(par), .lsu_grant_in(gnt), .lsu_grant_parity_in(gpar),
        .lsu_addr_out(addr), .lsu_write_enable_out(we), .lsu_byte_enables_out(be), .lsu_wdata_out(wdata),
        .lsu_resp_valid_in(rv), .lsu_resp_valid_parity_in(rvpar), .lsu_read_word_in(rword), .lsu_resp_error_in(1'b0),
        .parity_fault_out(fault));
    lsbm_mem mem (.clk_in(sys_clk_in), .reset_in(reset_in), .slow_in(slow), .req_in(req), .addr_in(addr), .we_in(we),
        .be_in(be), .wdata_in(wdata), .grant_out(gnt), .grant_parity_out(gpar), .resp_valid_out(rv),
        .resp_parity_out(rvpar), .read_word_out(rword));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Bounded wait for ready (0), done (1) or drained (2); a hang ends the run as a failure.
    task automatic wait_for(input int which);
        for (int i = 0; i < 60; i++) begin
            @(posedge sys_clk_in);
            #1;
            if (((which == 0) ? op_ready_out : (which == 1) ? op_done_out : drained_out) === 1'b1) return;
        end
        err_count++;
        finish_test();
    endtask
    // Offers one access until taken; waits for done unless it trapped or went into the buffer.
    task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a, d, input logic m, b);
        @(negedge sys_clk_in);
        {op_valid_in, op_write_in, op_size_in, op_addr_in, op_wdata_in, op_main_in, op_bufferable_in} = {1'b1, w, sz, a, d, m, b};
        wait_for(0);
        tr = op_trap_out;
        @(negedge sys_clk_in);
        op_valid_in = 1'b0;
        if (tr !== 1'b1 && !(w && b)) wait_for(1);
        rd = rdata;
    endtask
    // Every size stored and read back; a narrow load is checked only on the lanes it asked for.
    task automatic sizes_test(input logic s);
        @(negedge sys_clk_in);
        slow = s;
        access(1, lsbm_pkg::SIZE_WORD, 32'h10, 32'h44332211, 1, 0);
        access(1, lsbm_pkg::SIZE_BYTE, 32'h11, 32'h000000aa, 1, 0);
        access(1, lsbm_pkg::SIZE_HALF, 32'h12, 32'h0000ccbb, 1, 0);
        access(0, lsbm_pkg::SIZE_WORD, 32'h10, 32'h0, 1, 0);
        check("word", 32'hccbbaa11, rd);
        access(0, lsbm_pkg::SIZE_BYTE, 32'h13, 32'h0, 1, 0);
        check("byte", 32'hcc, rd & 32'hff);
        access(0, lsbm_pkg::SIZE_HALF, 32'h10, 32'h0, 1, 0);
        check("half", 32'haa11, rd & 32'hffff);
    endtask
    // Straddling word and halfword go out as two requests, lower word first.
    task automatic split_test;
        access(1, lsbm_pkg::SIZE_WORD, 32'h21, 32'h87654321, 1, 0);
        gaddr.delete();
        access(0, lsbm_pkg::SIZE_WORD, 32'h21, 32'h0, 1, 0);
        check("split word", 32'h87654321, rd);
        check("first request", 32'h20, gaddr[0]);
        check("second request", 32'h24, gaddr[1]);
        access(0, lsbm_pkg::SIZE_HALF, 32'h23, 32'h0, 1, 0);
        check("split half", 32'h8765, rd & 32'hffff);
        check("request count", 32'h4, 32'(gaddr.size()));
    endtask
    // A misaligned word in an I/O region traps and never reaches the bus.
    task automatic trap_test;
        gaddr.delete();
        access(0, lsbm_pkg::SIZE_WORD, 32'h22, 32'h0, 0, 0);
        repeat (4) @(posedge sys_clk_in);
        check("trap", 32'h1, 32'(tr));
        check("trap requests", 32'h0, 32'(gaddr.size()));
    endtask
    // A buffered store is taken before its grant, a later load sees it, and a drain waits for it.
    task automatic buffer_test;
        @(negedge sys_clk_in);
        slow = 1'b1;
        gaddr.delete();
        access(1, lsbm_pkg::SIZE_WORD, 32'h30, 32'h5a5aa5a5, 1, 1);
        check("taken before grant", 32'h0, 32'(gaddr.size()));
        access(0, lsbm_pkg::SIZE_WORD, 32'h30, 32'h0, 1, 0);
        check("load after store", 32'h5a5aa5a5, rd);
        access(1, lsbm_pkg::SIZE_WORD, 32'h34, 32'h1, 1, 1);
        drain_in = 1'b1;
        check("drained early", 32'h0, 32'(drained_out));
        wait_for(2);
        check("drained last", 32'h34, gaddr[$]);
        @(negedge sys_clk_in);
        drain_in = 1'b0;
    endtask
    // Reset, then every scenario in turn.
    initial begin
        repeat (8) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        reset_in = 1'b0;
        check("idle request", 32'h1, {30'h0, req, par});
        sizes_test(1'b0);
        sizes_test(1'b1);
        split_test();
        trap_test();
        buffer_test();
        check("parity fault", 32'h0, 32'(fault));
        check("error flag", 32'h0, 32'(oerr));
        finish_test();
    end
endmodule // lsbm_core_test
`default_nettype wire
